/* hw/serial_txrx.sv */
// Serial transceiver data paths with register port and flags.
// Assumes the CPU honours strobe timing and pins are synchronous.
//
// Overview of operation
// - Buffer-empty flag is set while transmit buffer holds nothing pending.
// - Buffer-empty interrupt requested while flag and its enable are set.
// - Writing data register clears the buffer-empty flag.
// - Transmit-complete set when frame sent and buffer empty.
// - Transmit-complete clears on interrupt service or writing one.
// - Transmit-complete interrupt raised when flag sets and enabled.
// - Parity bit inserted after last data bit when parity enabled.
// - Transmitter disable waits until shifter and buffer are empty.
// - Receive enable hands the receive pin to the receiver.
// - Synchronous mode uses external transfer clock for both directions.
// - Receiver samples after start bit until first stop bit.
// - Completed frame moves from shifter into receive buffer.
// - Unused high bits of short received characters read zero.
// - Ninth bit and error flags stored per buffer entry.
// - Shifter loads buffer when idle or right after last stop bit.
// - High bits beyond character size ignored on transmit.
// - Receive-complete shows unread data; disabling receiver flushes.
// - Two-entry receive buffer; overrun on third frame plus start bit.
`timescale 1ns/10ps
module serial_txrx
    import serial_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       rxd_pin,
    output logic            txd_out,
    output logic            txd_oe_n,
    output logic            tx_port_release,
    output logic            rx_port_release,
    input  wire logic       ext_transfer_clock,
    input  wire logic       tx_complete_ack,
    output logic            tx_buffer_empty_irq,
    output logic            tx_complete_irq
);
    typedef enum logic [2:0] {
        TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PAR, TX_STOP
    } tx_st_e;

    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] ctrl_b;
        logic [7:0] ctrl_c;
        logic [7:0] baud;
        logic [7:0] div;
        logic       xck_d;
        logic [8:0] tx_buf;
        logic       tx_buf_full;
        logic       tx_complete_flag;
        logic       tx_active;
        tx_st_e     tx_st;
        logic [8:0] tx_sh;
        logic [3:0] tx_cnt;
        logic       tx_par;
        logic       tx_stop2;
        logic       txd;
        rx_entry_s [RX_DEPTH-1:0] fifo;
        logic [1:0] fifo_cnt;
        logic       held_valid;
        rx_entry_s  held;
        logic       rx_busy_d;
    } top_state_s;
    top_state_s s_reg, s_next;

    frame_if fr ();

    logic       tx_enable_bit, rx_enable_bit, sync_mode;
    logic       bit_tick, xck_rise;
    logic [3:0] nbits;
    logic       tx_buffer_empty_flag, rx_complete_flag;
    logic       rd_data, start_seen;
    rx_entry_s  head;

    // Number of data bits from the size code
    function automatic logic [3:0] size_bits(input logic [2:0] code);
        if (code == SIZE_NINE) begin
            size_bits = 4'h9;
        end else begin
            size_bits = {1'b0, code} + 4'h5;
        end
    endfunction

    assign tx_enable_bit        = s_reg.ctrl_b[TXEN_POS];
    assign rx_enable_bit        = s_reg.ctrl_b[RXEN_POS];
    assign sync_mode            = s_reg.ctrl_c[SYNC_POS];
    assign nbits                = size_bits(s_reg.ctrl_c[2:0]);
    assign tx_buffer_empty_flag = !s_reg.tx_buf_full;
    assign rx_complete_flag     = s_reg.fifo_cnt != 2'h0;
    assign head                 = s_reg.fifo[0];
    assign rd_data              = rd && addr == ADDR_DATA;
    assign xck_rise             = ext_transfer_clock && !s_reg.xck_d;
    // Bit rate from divider, or transfer clock edges when synchronous
    assign bit_tick = sync_mode ? xck_rise
                                : (s_reg.div == 8'h00);
    // Start bit seen while a character is parked behind a full buffer
    assign start_seen = rx_enable_bit && bit_tick && !rxd_pin &&
                        s_reg.held_valid;

    // Receive shifter hookup
    assign fr.enable   = rx_enable_bit && !s_reg.held_valid;
    assign fr.bit_tick = bit_tick;
    assign fr.rxd      = rx_enable_bit ? rxd_pin : 1'b1;
    assign fr.nbits    = nbits;
    assign fr.par_en   = s_reg.ctrl_c[PEN_POS];
    assign fr.par_odd  = s_reg.ctrl_c[PODD_POS];

    serial_rx_shift u_rx (
        .clk   (clk),
        .reset (reset),
        .fr    (fr)
    );

    // Whole next-state computation
    always_comb begin
        rx_entry_s inc;
        logic      pop;
        inc          = fr.entry;
        pop          = 1'b0;
        s_next       = s_reg;
        s_next.xck_d = ext_transfer_clock;
        s_next.div   = (s_reg.div == 8'h00) ? s_reg.baud : s_reg.div - 8'h01;

        // Register writes
        if (wr) begin
            case (addr)
                ADDR_DATA: begin
                    s_next.tx_buf      = {s_reg.ctrl_b[TX8_POS], wdata};
                    s_next.tx_buf_full = 1'b1;
                end
                ADDR_STATUS_A: if (wdata[TXC_POS]) begin
                    s_next.tx_complete_flag = 1'b0;
                end
                ADDR_CTRL_B: begin
                    // Received ninth bit is read-only
                    s_next.ctrl_b = {wdata[7:2], s_reg.ctrl_b[1], wdata[0]};
                end
                ADDR_CTRL_C: s_next.ctrl_c = wdata;
                ADDR_BAUD:   s_next.baud   = wdata;
                default: ;
            endcase
        end
        if (tx_complete_ack) begin
            s_next.tx_complete_flag = 1'b0;
        end
        // Transmitter stays driving until all pending data is out
        if (s_next.ctrl_b[TXEN_POS]) begin
            s_next.tx_active = 1'b1;
        end else if (!s_reg.tx_buf_full && s_reg.tx_st == TX_IDLE) begin
            s_next.tx_active = 1'b0;
        end

        // Transmit shifter
        if (bit_tick) begin
            case (s_reg.tx_st)
                TX_IDLE: s_next.txd = 1'b1;
                TX_LOAD: begin
                    // Start bit waits for a tick so it lasts a full bit
                    s_next.txd   = 1'b0;
                    s_next.tx_st = TX_START;
                end
                TX_START: begin
                    s_next.txd   = s_reg.tx_sh[0];
                    s_next.tx_sh = {1'b0, s_reg.tx_sh[8:1]};
                    s_next.tx_st = TX_DATA;
                end
                TX_DATA: begin
                    if (s_reg.tx_cnt == 4'h1) begin
                        s_next.txd   = s_reg.ctrl_c[PEN_POS] ? s_reg.tx_par
                                                             : 1'b1;
                        s_next.tx_st = s_reg.ctrl_c[PEN_POS] ? TX_PAR
                                                             : TX_STOP;
                        s_next.tx_stop2 = s_reg.ctrl_c[STOP_POS];
                    end else begin
                        s_next.txd   = s_reg.tx_sh[0];
                        s_next.tx_sh = {1'b0, s_reg.tx_sh[8:1]};
                    end
                    s_next.tx_cnt = s_reg.tx_cnt - 4'h1;
                end
                TX_PAR: begin
                    s_next.txd   = 1'b1;
                    s_next.tx_st = TX_STOP;
                end
                TX_STOP: begin
                    if (s_reg.tx_stop2) begin
                        s_next.tx_stop2 = 1'b0;
                    end else begin
                        s_next.tx_st = TX_IDLE;
                        if (!s_reg.tx_buf_full) begin
                            s_next.tx_complete_flag = 1'b1;
                        end
                    end
                end
                default: s_next.tx_st = TX_IDLE;
            endcase
        end
        // Load shifter when idle or right at the end of the last stop bit
        if (s_reg.tx_buf_full && s_reg.tx_active &&
            (s_reg.tx_st == TX_IDLE ||
             (bit_tick && s_reg.tx_st == TX_STOP && !s_reg.tx_stop2))) begin
            // Mask bits above the character size
            s_next.tx_sh = s_reg.tx_buf & ((9'h001 << nbits) - 9'h001);
            s_next.tx_par = s_reg.ctrl_c[PODD_POS] ^
                            (^(s_reg.tx_buf & ((9'h001 << nbits) - 9'h001)));
            s_next.tx_cnt      = nbits;
            s_next.tx_st       = bit_tick ? TX_START : TX_LOAD;
            s_next.tx_buf_full = wr && addr == ADDR_DATA;
            if (bit_tick) begin
                s_next.txd   = 1'b0;
                s_next.tx_sh = s_reg.tx_buf & ((9'h001 << nbits) - 9'h001);
            end
        end
        if (s_reg.tx_st == TX_START && bit_tick) begin
            s_next.txd = s_reg.tx_sh[0];
        end

        // Receive buffer: pop on data read, push completed frames
        if (rd_data && s_reg.fifo_cnt != 2'h0) begin
            pop         = 1'b1;
            s_next.fifo[0]  = s_reg.fifo[1];
            s_next.fifo[1]  = '0;
            s_next.fifo_cnt = s_reg.fifo_cnt - 2'h1;
        end
        if (start_seen) begin
            s_next.held.dor = 1'b1;
        end
        if (fr.done) begin
            s_next.held       = inc;
            s_next.held_valid = 1'b1;
        end
        if (s_reg.held_valid && s_next.fifo_cnt != 2'(RX_DEPTH)) begin
            s_next.fifo[s_next.fifo_cnt[0]] = s_reg.held;
            s_next.fifo_cnt   = s_next.fifo_cnt + 2'h1;
            s_next.held_valid = 1'b0;
        end
        s_next.rx_busy_d = pop;
        if (!rx_enable_bit) begin
            s_next.fifo_cnt   = 2'h0;
            s_next.held_valid = 1'b0;
            s_next.held       = '0;
        end

        // Read data, one cycle after the strobe
        s_next.rdata = 8'h00;
        if (rd) begin
            case (addr)
                ADDR_DATA: s_next.rdata = rx_complete_flag ? head.data
                                                           : 8'h00;
                ADDR_STATUS_A: begin
                    s_next.rdata[RXC_POS]  = rx_complete_flag;
                    s_next.rdata[TXC_POS]  = s_reg.tx_complete_flag;
                    s_next.rdata[UDRE_POS] = tx_buffer_empty_flag;
                    s_next.rdata[FE_POS]   = rx_complete_flag & head.fe;
                    s_next.rdata[DOR_POS]  = rx_complete_flag & head.dor;
                    s_next.rdata[UPE_POS]  = rx_complete_flag & head.upe;
                end
                ADDR_CTRL_B: begin
                    s_next.rdata = s_reg.ctrl_b;
                    s_next.rdata[RX8_POS] = rx_complete_flag & head.ninth;
                end
                ADDR_CTRL_C: s_next.rdata = s_reg.ctrl_c;
                ADDR_BAUD:   s_next.rdata = s_reg.baud;
                default:     s_next.rdata = 8'h00;
            endcase
        end
        // Completion set by a final stop bit wins over a same-cycle clear
        if (bit_tick && s_reg.tx_st == TX_STOP && !s_reg.tx_stop2 &&
            !s_reg.tx_buf_full) begin
            s_next.tx_complete_flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg        <= '0;
            s_reg.ctrl_c <= CTRL_C_RESET;
            s_reg.baud   <= BAUD_RESET;
            s_reg.txd    <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs; interrupt requests stand as levels for the CPU core
    assign rdata               = s_reg.rdata;
    assign txd_out             = s_reg.tx_active ? s_reg.txd : 1'b1;
    assign txd_oe_n            = !s_reg.tx_active;
    assign tx_port_release     = !s_reg.tx_active;
    assign rx_port_release     = !rx_enable_bit;
    assign tx_buffer_empty_irq = tx_buffer_empty_flag &
                                 s_reg.ctrl_b[UDRIE_POS];
    assign tx_complete_irq     = s_reg.tx_complete_flag &
                                 s_reg.ctrl_b[TXCIE_POS];
endmodule

/* include/serial_pkg.sv */
// Constants and types shared by the serial transceiver data paths.
// Assumes a 100 MHz system clock and a plain strobe register port.
package serial_pkg;
    // Register offsets
    localparam logic [2:0] ADDR_DATA     = 3'h0;
    localparam logic [2:0] ADDR_STATUS_A = 3'h1;
    localparam logic [2:0] ADDR_CTRL_B   = 3'h2;
    localparam logic [2:0] ADDR_CTRL_C   = 3'h3;
    localparam logic [2:0] ADDR_BAUD     = 3'h4;
    // Status A bits
    localparam int RXC_POS  = 7;
    localparam int TXC_POS  = 6;
    localparam int UDRE_POS = 5;
    localparam int FE_POS   = 4;
    localparam int DOR_POS  = 3;
    localparam int UPE_POS  = 2;
    // Control B bits
    localparam int RXEN_POS  = 4;
    localparam int TXEN_POS  = 3;
    localparam int RX8_POS   = 1;
    localparam int TX8_POS   = 0;
    localparam int TXCIE_POS = 6;
    localparam int UDRIE_POS = 5;
    // Control C bits: [7] sync, [5] parity on, [4] odd, [3] two stop,
    // [2:0] character size code
    localparam int SYNC_POS = 7;
    localparam int PEN_POS  = 5;
    localparam int PODD_POS = 4;
    localparam int STOP_POS = 3;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    // Reset values
    localparam logic [7:0] CTRL_C_RESET = 8'h06;
    localparam logic [7:0] BAUD_RESET   = 8'h0F;
    localparam int RX_DEPTH = 2;
    // Receive buffer entry: ninth bit, errors, data
    typedef struct packed {
        logic       ninth;
        logic       fe;
        logic       dor;
        logic       upe;
        logic [7:0] data;
    } rx_entry_s;
endpackage

/* include/frame_if.sv */
// Frame format bundle passed from the register file to the receiver.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface frame_if;
    import serial_pkg::*;
    logic       enable;
    logic       bit_tick;
    logic       rxd;
    logic [3:0] nbits;
    logic       par_en;
    logic       par_odd;
    logic       done;
    rx_entry_s  entry;
    modport ctrl (output enable, bit_tick, rxd, nbits, par_en, par_odd,
                  input done, entry);
    modport rx   (input enable, bit_tick, rxd, nbits, par_en, par_odd,
                  output done, entry);
endinterface

/* hw/serial_rx_shift.sv */
// Receive shifter: start detect, bit sampling, parity check.
// Assumes bit_tick is one pulse per bit period and rxd is synchronous.
`timescale 1ns/10ps
module serial_rx_shift
    import serial_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    frame_if.rx       fr
);
    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} rx_st_e;
    typedef struct packed {
        rx_st_e     st;
        logic [3:0] cnt;
        logic [8:0] sh;
        logic       par;
        logic       done;
        rx_entry_s  entry;
    } rx_state_s;
    rx_state_s s_reg, s_next;

    // Sample on bit tick; stop bit alone finishes the frame
    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (!fr.enable) begin
            s_next.st = RX_IDLE;
        end else if (fr.bit_tick) begin
            case (s_reg.st)
                RX_IDLE: if (!fr.rxd) begin
                    s_next.st  = RX_DATA;
                    s_next.cnt = 4'h0;
                    s_next.sh  = 9'h000;
                    s_next.par = fr.par_odd;
                end
                RX_DATA: begin
                    s_next.sh  = {fr.rxd, s_reg.sh[8:1]};
                    s_next.par = s_reg.par ^ fr.rxd;
                    s_next.cnt = s_reg.cnt + 4'h1;
                    if (s_reg.cnt + 4'h1 == fr.nbits) begin
                        s_next.st = fr.par_en ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: begin
                    s_next.par = s_reg.par ^ fr.rxd;
                    s_next.st  = RX_STOP;
                end
                RX_STOP: begin
                    // Second stop bit is never waited for
                    s_next.st          = RX_IDLE;
                    s_next.done        = 1'b1;
                    s_next.entry.fe    = !fr.rxd;
                    s_next.entry.upe   = fr.par_en & s_reg.par;
                    s_next.entry.dor   = 1'b0;
                    // Right-align, unused high bits become zero
                    s_next.entry.data  = 8'(s_reg.sh >> (4'h9 - fr.nbits));
                    // Ninth bit only exists in nine-bit frames
                    s_next.entry.ninth = (fr.nbits == 4'h9) &
                                         s_reg.sh[8];
                end
                default: s_next.st = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign fr.done  = s_reg.done;
    assign fr.entry = s_reg.entry;
endmodule

/* tb/serial_txrx_asserts.sv */
// Concurrent checks on the serial transceiver top-level ports.
// Assumes one clock domain with an active-high asynchronous reset.
`timescale 1ns/10ps
module serial_txrx_check
    import serial_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic [7:0] rdata,
    input wire logic       txd_out,
    input wire logic       txd_oe_n,
    input wire logic       rx_port_release,
    input wire logic       tx_complete_ack,
    input wire logic       tx_buffer_empty_irq,
    input wire logic       tx_complete_irq
);
    // Slowest divider gives 256 clocks a bit, plus the load cycle
    localparam int START_MAX = 300;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Strobes that start or steer transfers
    sequence data_wr_s;
        wr && addr == ADDR_DATA;
    endsequence
    sequence idle_wr_s;
        data_wr_s ##0 (tx_complete_irq && !txd_oe_n);
    endsequence
    sequence ctrl_wr_s;
        wr && addr == ADDR_CTRL_B;
    endsequence
    empty_clear_a: assert property (data_wr_s |=> !tx_buffer_empty_irq)
        else $error("empty request held after data write");
    empty_mask_a: assert property (
        ctrl_wr_s ##0 !wdata[UDRIE_POS] |=> !tx_buffer_empty_irq)
        else $error("empty request not masked");
    rx_take_a: assert property (
        ctrl_wr_s ##0 wdata[RXEN_POS] |=> !rx_port_release)
        else $error("receive pin not taken");
    release_idle_a: assert property (txd_oe_n |-> txd_out)
        else $error("released line not high");
    tx_start_a: assert property (idle_wr_s |-> ##[1:START_MAX] !txd_out)
        else $error("idle shifter did not start");
    txc_ack_a: assert property (
        tx_complete_irq && tx_complete_ack |=> !tx_complete_irq)
        else $error("complete flag kept after service");
    txc_clear_a: assert property (
        tx_complete_irq && wr && addr == ADDR_STATUS_A && wdata[TXC_POS]
        |=> !tx_complete_irq)
        else $error("complete flag kept after write one");
    reset_state_a: assert property (
        $fell(reset) |-> txd_out && txd_oe_n && !tx_complete_irq
        && rdata == 8'h00)
        else $error("wrong state after reset");
endmodule

bind serial_txrx serial_txrx_check chk_u (
    .clk                 (clk),
    .reset               (reset),
    .addr                (addr),
    .wdata               (wdata),
    .wr                  (wr),
    .rdata               (rdata),
    .txd_out             (txd_out),
    .txd_oe_n            (txd_oe_n),
    .rx_port_release     (rx_port_release),
    .tx_complete_ack     (tx_complete_ack),
    .tx_buffer_empty_irq (tx_buffer_empty_irq),
    .tx_complete_irq     (tx_complete_irq)
);

/* tb/serial_far_end.sv */
// Far-end serial transceiver model on the transmit and receive lines.
// Assumes an idle-high line and BIT_CLKS system clocks per bit.
`timescale 1ns/10ps
module serial_far_end #(
    parameter int BIT_CLKS = 4
) (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    initial rxd = 1'b1;
    // Start bit, n bits LSB first, then one idle bit
    task automatic send(input logic [11:0] bits, input int n);
        int i;
        @(posedge clk);
        rxd <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk);
        for (i = 0; i < n; i++) begin
            rxd <= bits[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk);
    endtask
    // Mid-bit sampling so the device's tick phase does not matter
    task automatic recv(input int n, output logic [11:0] bits);
        int i;
        bits = '0;
        do @(posedge clk); while (txd !== 1'b0);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (i = 0; i < n; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            bits[i] = txd;
        end
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the serial transceiver data paths.
// Assumes the checker is bound and the far-end model sits on the lines.
`timescale 1ns/10ps
module tb_top;
    import serial_pkg::*;
    logic        clk, reset, wr, rd, rxd, txd, oe_n, txrel, rxrel;
    logic        ack, e_irq, c_irq;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, v;
    logic [11:0] b1, b2;
    int          n_mismatch, samples_checked, i;
    logic [1:0]  xdiv = 2'h0;
    localparam logic [7:0] ON = 8'h78;
    localparam logic [7:0] FC [5] = '{8'h03, 8'h23, 8'h30, 8'h27, 8'h83};
    localparam logic [8:0] FD [5] = '{9'h0A6, 9'h0B1, 9'h0FF, 9'h1C5, 9'h069};
    localparam int         FN [5] = '{8, 8, 5, 9, 8};
    serial_txrx dut_u (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd_pin(rxd),
        .txd_out(txd), .txd_oe_n(oe_n), .tx_port_release(txrel),
        .rx_port_release(rxrel), .ext_transfer_clock(xdiv[1]),
        .tx_complete_ack(ack), .tx_buffer_empty_irq(e_irq),
        .tx_complete_irq(c_irq));
    serial_far_end #(.BIT_CLKS(4)) far_u (.clk(clk), .txd(txd), .rxd(rxd));
    // Far end's transfer clock runs free, one rising edge per four clocks
    always @(posedge clk) xdiv <= xdiv + 2'h1;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // Let the write land before callers look at outputs
        #1;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Line image after the start bit: data, optional parity, stop
    function automatic logic [11:0] frame(input logic [8:0] d, input int n,
                                         input logic p, input logic o);
        logic [8:0]  m;
        logic [11:0] f;
        m = d & ((9'h001 << n) - 9'h001);
        f = {3'h0, m};
        f[n] = p ? (^m ^ o) : 1'b1;
        if (p) f[n + 1] = 1'b1;
        return f;
    endfunction
    task automatic wait_txc();
        int k;
        for (k = 0; k < 400 && c_irq !== 1'b1; k++) @(posedge clk);
        chk(c_irq, 1'b1);
    endtask
    task automatic wait_rxc();
        int k;
        v = 8'h00;
        for (k = 0; k < 50 && v[RXC_POS] !== 1'b1; k++)
            rd_reg(ADDR_STATUS_A, v);
        chk(v[RXC_POS], 1'b1);
    endtask
    task automatic rx_send(input logic [8:0] d, input int n, input logic s);
        logic [11:0] f;
        f = frame(d, n, 1'b0, 1'b0);
        f[n] = s;
        far_u.send(f, n + 1);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Whole run is about a thousand cycles; wide margin
    initial begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        {reset, wr, rd, ack, addr, wdata} = {1'b1, 14'h0000};
        {n_mismatch, samples_checked} = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd_reg(ADDR_STATUS_A, v);
        chk(v, 8'h20);
        rd_reg(3'h5, v);
        chk(v, 8'h00);
        rd_reg(ADDR_CTRL_C, v);
        chk(v, CTRL_C_RESET);
        wr_reg(ADDR_BAUD, 8'h03); // Four clocks a bit keeps frames short
        wr_reg(ADDR_CTRL_B, ON);
        chk({e_irq, rxrel}, 2'b10);
        // Sizes 8, 5 and 9, each parity mode, the ninth bit, then synchronous mode
        for (i = 0; i < 5; i++) begin
            wr_reg(ADDR_CTRL_C, FC[i]);
            wr_reg(ADDR_CTRL_B, ON | {7'h00, FD[i][8]});
            fork
                far_u.recv(FN[i] + 1 + FC[i][PEN_POS], b1);
                wr_reg(ADDR_DATA, FD[i][7:0]);
            join
            chk(b1, frame(FD[i], FN[i], FC[i][PEN_POS], FC[i][PODD_POS]));
            wait_txc();
            ack <= 1'b1;
            @(posedge clk);
            ack <= 1'b0;
            @(posedge clk);
            chk(c_irq, 1'b0);
        end
        wr_reg(ADDR_CTRL_C, 8'h03);
        wr_reg(ADDR_CTRL_B, ON);
        fork
            begin
                far_u.recv(9, b1);
                far_u.recv(9, b2);
            end
            begin
                wr_reg(ADDR_DATA, 8'h5A);
                wr_reg(ADDR_DATA, 8'hC3);
                rd_reg(ADDR_STATUS_A, v);
                chk(v[6:5], 2'b00);
            end
        join
        chk(b1, frame(9'h05A, 8, 1'b0, 1'b0));
        chk(b2, frame(9'h0C3, 8, 1'b0, 1'b0));
        wait_txc();
        // Transmit off while a frame is still going out
        fork
            far_u.recv(9, b1);
            begin
                wr_reg(ADDR_DATA, 8'h3C);
                wr_reg(ADDR_CTRL_B, 8'h70);
                chk(oe_n, 1'b0);
            end
        join
        chk(b1, frame(9'h03C, 8, 1'b0, 1'b0));
        repeat (12) @(posedge clk);
        chk({oe_n, txrel}, 2'b11);
        wr_reg(ADDR_STATUS_A, 8'h40);
        rd_reg(ADDR_STATUS_A, v);
        chk(v[TXC_POS], 1'b0);
        // Receive side: plain, short, ninth bit with bad stop
        rx_send(9'h0A5, 8, 1'b1);
        wait_rxc();
        chk(v[4:2], 3'b000);
        rd_reg(ADDR_DATA, v);
        chk(v, 8'hA5);
        wr_reg(ADDR_CTRL_C, 8'h00);
        rx_send(9'h1FF, 5, 1'b1);
        wait_rxc();
        rd_reg(ADDR_DATA, v);
        chk(v, 8'h1F);
        wr_reg(ADDR_CTRL_C, 8'h07);
        rx_send(9'h1C3, 9, 1'b0);
        wait_rxc();
        chk(v[FE_POS], 1'b1);
        rd_reg(ADDR_CTRL_B, v);
        chk(v[RX8_POS], 1'b1);
        rd_reg(ADDR_DATA, v);
        chk(v, 8'hC3);
        // Four frames unread: third entry carries the overrun
        wr_reg(ADDR_CTRL_C, 8'h03);
        for (i = 0; i < 4; i++) rx_send({1'b0, 4'(i + 1), 4'(i + 1)}, 8, 1'b1);
        for (i = 0; i < 3; i++) begin
            rd_reg(ADDR_STATUS_A, v);
            chk(v[DOR_POS], i == 2);
            if (i < 2) begin
                rd_reg(ADDR_DATA, v);
                chk(v, {4'(i + 1), 4'(i + 1)});
            end
        end
        wr_reg(ADDR_CTRL_B, 8'h60);
        rd_reg(ADDR_STATUS_A, v);
        chk({v[RXC_POS], rxrel}, 2'b01);
        report_and_stop();
    end
endmodule
